/* File: asc_pkg.sv */
package asc_pkg;
    localparam int DATA_W = 8;
    localparam int QUEUE_DEPTH = 3;
    localparam int OVERSAMPLE = 16;
    localparam int HALF_BIT_16X = 8;
    localparam int BREAK_HIGH_EDGES = 2;
    localparam logic [1:0] CLK_SRC_BRG = 2'h0;
    localparam logic [1:0] CLK_SRC_CT = 2'h1;
    localparam logic [1:0] CLK_SRC_EXT = 2'h2;
    localparam int ERR_PAR = 0;
    localparam int ERR_FRM = 1;
    localparam int ERR_BRK = 2;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
endpackage : asc_pkg

/* File: asc_tick_gen.sv */
module asc_tick_gen (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] src_sel_i,
    input wire logic brg_clk_i,
    input wire logic ct_clk_i,
    input wire logic ext_clk_i,
    output logic tick_o
);
    logic [2:0] brg_sync_reg;
    logic [2:0] ct_sync_reg;
    logic [2:0] ext_sync_reg;
    logic sel_reg;
    logic sel_next;

    // ==========================================
    // Three-stage input filters
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            brg_sync_reg <= 3'h0;
            ct_sync_reg <= 3'h0;
            ext_sync_reg <= 3'h0;
        end else begin
            brg_sync_reg <= {brg_sync_reg[1:0], brg_clk_i};
            ct_sync_reg <= {ct_sync_reg[1:0], ct_clk_i};
            ext_sync_reg <= {ext_sync_reg[1:0], ext_clk_i};
        end
    end

    // ==========================================
    // Source select and rising edge
    always_comb begin
        sel_next = sel_reg;
        if (src_sel_i == asc_pkg::CLK_SRC_BRG) begin
            if (brg_sync_reg[2] == brg_sync_reg[1]) sel_next = brg_sync_reg[1];
        end else if (src_sel_i == asc_pkg::CLK_SRC_CT) begin
            if (ct_sync_reg[2] == ct_sync_reg[1]) sel_next = ct_sync_reg[1];
        end else begin
            if (ext_sync_reg[2] == ext_sync_reg[1]) sel_next = ext_sync_reg[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sel_reg <= 1'b0;
            tick_o <= 1'b0;
        end else begin
            sel_reg <= sel_next;
            tick_o <= sel_next & ~sel_reg;
        end
    end
endmodule : asc_tick_gen

/* File: asc_rx_queue.sv */
module asc_rx_queue #(
    parameter int DEPTH = asc_pkg::QUEUE_DEPTH,
    parameter int WIDTH = asc_pkg::DATA_W + 3
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic realign_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    input wire logic pop_i,
    output logic [WIDTH-1:0] head_o,
    output logic [1:0] count_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [1:0] wr_reg;
    logic [1:0] rd_reg;

    if (DEPTH != 3) begin : g_depth_check
        $error("asc_rx_queue supports depth three only");
    end

    function automatic logic [1:0] bump(input logic [1:0] p);
        bump = (p == 2'(DEPTH - 1)) ? 2'h0 : p + 2'h1;
    endfunction : bump

    // ==========================================
    // Storage, never cleared
    always_ff @(posedge clk_i) begin
        if (push_i && count_o != 2'(DEPTH)) mem[wr_reg] <= push_data_i;
    end

    // ==========================================
    // Pointers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_reg <= 2'h0;
            rd_reg <= 2'h0;
            count_o <= 2'h0;
        end else if (realign_i) begin
            rd_reg <= wr_reg;
            count_o <= 2'h0;
        end else begin
            if (push_i && count_o != 2'(DEPTH)) wr_reg <= bump(wr_reg);
            if (pop_i && count_o != 2'h0) rd_reg <= bump(rd_reg);
            if ((push_i && count_o != 2'(DEPTH)) && !(pop_i && count_o != 2'h0)) count_o <= count_o + 2'h1;
            else if (!(push_i && count_o != 2'(DEPTH)) && (pop_i && count_o != 2'h0)) count_o <= count_o - 2'h1;
        end
    end

    assign head_o = mem[rd_reg];
endmodule : asc_rx_queue

/* File: asc_channel.sv */
module asc_channel (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic brg_clk_i,
    input wire logic ct_clk_i,
    input wire logic ext_rx_clk_i,
    input wire logic ext_tx_clk_i,
    input wire logic [1:0] rx_clk_sel_i,
    input wire logic [1:0] tx_clk_sel_i,
    input wire logic rx_16x_i,
    input wire logic tx_16x_i,
    input wire logic [1:0] char_len_i,
    input wire logic parity_en_i,
    input wire logic parity_odd_i,
    input wire logic [1:0] stop_bits_i,
    input wire logic block_err_i,
    input wire logic cts_gate_en_i,
    input wire logic tx_rts_ctrl_i,
    input wire logic rx_rts_ctrl_i,
    input wire logic rts_set_i,
    input wire logic tx_enable_i,
    input wire logic tx_disable_i,
    input wire logic tx_reset_i,
    input wire logic rx_enable_i,
    input wire logic rx_disable_i,
    input wire logic rx_reset_i,
    input wire logic err_reset_i,
    input wire logic break_start_i,
    input wire logic break_stop_i,
    input wire logic tx_write_i,
    input wire logic [7:0] tx_data_i,
    input wire logic rx_read_i,
    input wire logic rx_int_full_i,
    input wire logic tx_irq_aux_i,
    input wire logic rx_irq_aux_i,
    input wire logic serial_in_i,
    input wire logic clear_to_send_in_n_i,
    input wire logic crystal_ref_clock_i,
    output logic serial_out_chan_a_o,
    output logic request_to_send_out_n_o,
    output logic [7:0] rx_holding_reg_o,
    output logic tx_holding_free_o,
    output logic tx_all_sent_o,
    output logic rx_char_available_o,
    output logic rx_queue_full_o,
    output logic overrun_flag_o,
    output logic parity_err_o,
    output logic framing_err_o,
    output logic break_flag_o,
    output logic irq_tx_o,
    output logic irq_rx_o,
    output logic aux_out_tx_n_o,
    output logic aux_out_rx_n_o
);
    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_RTS} asc_tx_state_type;
    typedef enum {RX_HUNT, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} asc_rx_state_type;
    asc_tx_state_type tx_state_reg;
    asc_rx_state_type rx_state_reg;

    logic rx_tick;
    logic tx_tick;
    logic [2:0] rxd_sync_reg;
    logic [2:0] cts_sync_reg;
    logic [2:0] xtal_sync_reg;
    logic rxd_reg;
    logic cts_n_reg;
    logic tx_en_reg;
    logic thr_full_reg;
    logic [7:0] thr_reg;
    logic [7:0] tsr_reg;
    logic [3:0] tx_cnt_reg;
    logic [3:0] tx_bit_reg;
    logic tx_par_reg;
    logic brk_tx_reg;
    logic [3:0] rx_cnt_reg;
    logic [3:0] rx_bit_reg;
    logic [7:0] rsr_reg;
    logic rx_par_reg;
    logic rx_en_reg;
    logic held_reg;
    logic [10:0] held_word_reg;
    logic push;
    logic [10:0] push_word;
    logic [10:0] head;
    logic [1:0] count;
    logic [2:0] err_acc_reg;
    logic [1:0] brk_hi_reg;
    logic rts_n_reg;
    logic rx_rts_hold_reg;
    logic [3:0] tx_bits;
    logic [3:0] tx_full;
    logic [3:0] rx_full;
    logic [3:0] rx_half;
    logic tx_bit_end;
    logic rx_centre;
    logic [7:0] rx_mask;
    logic fe_restart;

    // ==========================================
    // Bit clocks and synchronisers
    asc_tick_gen u_rx_tick (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .src_sel_i(rx_clk_sel_i),
        .brg_clk_i(brg_clk_i),
        .ct_clk_i(ct_clk_i),
        .ext_clk_i(ext_rx_clk_i),
        .tick_o(rx_tick)
    );
    asc_tick_gen u_tx_tick (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .src_sel_i(tx_clk_sel_i),
        .brg_clk_i(brg_clk_i),
        .ct_clk_i(ct_clk_i),
        .ext_clk_i(ext_tx_clk_i),
        .tick_o(tx_tick)
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rxd_sync_reg <= 3'h7;
            cts_sync_reg <= 3'h7;
            xtal_sync_reg <= 3'h0;
            rxd_reg <= 1'b1;
            cts_n_reg <= 1'b1;
        end else begin
            rxd_sync_reg <= {rxd_sync_reg[1:0], serial_in_i};
            cts_sync_reg <= {cts_sync_reg[1:0], clear_to_send_in_n_i};
            xtal_sync_reg <= {xtal_sync_reg[1:0], crystal_ref_clock_i};
            if (rxd_sync_reg[2] == rxd_sync_reg[1]) rxd_reg <= rxd_sync_reg[1];
            if (cts_sync_reg[2] == cts_sync_reg[1]) cts_n_reg <= cts_sync_reg[1];
        end
    end

    assign tx_full = tx_16x_i ? 4'(asc_pkg::OVERSAMPLE - 1) : 4'h0;
    assign rx_full = rx_16x_i ? 4'(asc_pkg::OVERSAMPLE - 1) : 4'h0;
    assign rx_half = rx_16x_i ? 4'(asc_pkg::HALF_BIT_16X - 1) : 4'h0;
    assign tx_bits = 4'h5 + {2'h0, char_len_i};
    assign tx_bit_end = tx_tick && tx_cnt_reg == tx_full;
    assign rx_centre = rx_tick && rx_cnt_reg == rx_full;
    assign rx_mask = 8'hFF >> (2'h3 - char_len_i);

    // ==========================================
    // Transmitter
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || tx_reset_i) begin
            tx_en_reg <= 1'b0;
            thr_full_reg <= 1'b0;
            tx_state_reg <= TX_IDLE;
            tx_cnt_reg <= 4'h0;
            tx_bit_reg <= 4'h0;
            tsr_reg <= asc_pkg::DATA_RESET;
            thr_reg <= asc_pkg::DATA_RESET;
            tx_par_reg <= 1'b0;
            brk_tx_reg <= 1'b0;
            serial_out_chan_a_o <= 1'b1;
            tx_all_sent_o <= 1'b0;
        end else begin
            if (tx_enable_i) tx_en_reg <= 1'b1;
            else if (tx_disable_i) tx_en_reg <= 1'b0;
            if (break_start_i) brk_tx_reg <= 1'b1;
            else if (break_stop_i) brk_tx_reg <= 1'b0;
            if (tx_write_i && tx_en_reg && !thr_full_reg) begin
                thr_reg <= tx_data_i;
                thr_full_reg <= 1'b1;
                tx_all_sent_o <= 1'b0;
            end
            if (tx_tick) tx_cnt_reg <= tx_bit_end ? 4'h0 : tx_cnt_reg + 4'h1;
            case (tx_state_reg)
                TX_IDLE, TX_RTS: begin
                    serial_out_chan_a_o <= ~brk_tx_reg;
                    if (thr_full_reg && tx_bit_end && (!cts_gate_en_i || !cts_n_reg)) begin
                        tsr_reg <= thr_reg;
                        tx_par_reg <= parity_odd_i;
                        thr_full_reg <= 1'b0;
                        tx_state_reg <= TX_START;
                        serial_out_chan_a_o <= brk_tx_reg ? 1'b0 : 1'b0;
                    end else if (tx_state_reg == TX_RTS && tx_bit_end) begin
                        tx_state_reg <= TX_IDLE;
                    end
                end
                TX_START, TX_DATA: begin
                    if (tx_bit_end) begin
                        serial_out_chan_a_o <= tsr_reg[0] & ~brk_tx_reg;
                        tx_par_reg <= tx_par_reg ^ tsr_reg[0];
                        tsr_reg <= {1'b0, tsr_reg[7:1]};
                        tx_bit_reg <= (tx_state_reg == TX_START) ? 4'h1 : tx_bit_reg + 4'h1;
                        tx_state_reg <= TX_DATA;
                        if (tx_state_reg == TX_DATA && tx_bit_reg == tx_bits) begin
                            serial_out_chan_a_o <= parity_en_i ? tx_par_reg & ~brk_tx_reg : ~brk_tx_reg;
                            tx_state_reg <= parity_en_i ? TX_PAR : TX_STOP;
                            tx_bit_reg <= 4'h0;
                        end
                    end
                end
                TX_PAR: begin
                    if (tx_bit_end) begin
                        serial_out_chan_a_o <= ~brk_tx_reg;
                        tx_state_reg <= TX_STOP;
                        tx_bit_reg <= 4'h0;
                    end
                end
                default: begin
                    if (tx_bit_end) begin
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                        if (tx_bit_reg == {2'h0, stop_bits_i}) begin
                            tx_state_reg <= TX_RTS;
                            tx_all_sent_o <= ~thr_full_reg & ~(tx_write_i & tx_en_reg);
                            serial_out_chan_a_o <= ~brk_tx_reg;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) tx_holding_free_o <= 1'b0;
        else tx_holding_free_o <= tx_en_reg && !thr_full_reg && !tx_reset_i;
    end

    // ==========================================
    // Receiver
    assign fe_restart = rx_centre && rx_state_reg == RX_STOP && !rxd_reg && rsr_reg != 8'h00;
    assign push_word = {rx_state_reg == RX_STOP && !rxd_reg && rsr_reg == 8'h00
                        && rx_par_reg == (parity_en_i & parity_odd_i),
                        !rxd_reg, rx_par_reg, rsr_reg & rx_mask};

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || rx_reset_i) begin
            rx_en_reg <= 1'b0;
            rx_state_reg <= RX_HUNT;
            rx_cnt_reg <= 4'h0;
            rx_bit_reg <= 4'h0;
            rsr_reg <= asc_pkg::DATA_RESET;
            rx_par_reg <= 1'b0;
            held_reg <= 1'b0;
            held_word_reg <= 11'h000;
            brk_hi_reg <= 2'h0;
            overrun_flag_o <= 1'b0;
            push <= 1'b0;
        end else begin
            push <= 1'b0;
            if (rx_enable_i) rx_en_reg <= 1'b1;
            else if (rx_disable_i) rx_en_reg <= 1'b0;
            if (err_reset_i) overrun_flag_o <= 1'b0;
            if (held_reg && count != 2'(asc_pkg::QUEUE_DEPTH)) begin
                push <= 1'b1;
                held_reg <= 1'b0;
            end
            if (rx_tick) rx_cnt_reg <= rx_centre ? 4'h0 : rx_cnt_reg + 4'h1;
            case (rx_state_reg)
                RX_HUNT: begin
                    rx_cnt_reg <= 4'h0;
                    if (rx_en_reg && !rxd_reg) rx_state_reg <= RX_START;
                end
                RX_START: begin
                    if (rx_tick && rx_cnt_reg == rx_half) begin
                        rx_cnt_reg <= 4'h0;
                        rx_par_reg <= parity_odd_i;
                        rsr_reg <= 8'h00;
                        rx_bit_reg <= 4'h0;
                        rx_state_reg <= rxd_reg ? RX_HUNT : RX_DATA;
                        if (!rxd_reg && held_reg && count == 2'(asc_pkg::QUEUE_DEPTH)) begin
                            held_reg <= 1'b0;
                            overrun_flag_o <= 1'b1;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_centre) begin
                        rsr_reg <= {rsr_reg[7:0] >> 1} | ({7'h00, rxd_reg} << (tx_bits - 4'h1));
                        rx_par_reg <= rx_par_reg ^ rxd_reg;
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                        if (rx_bit_reg == tx_bits - 4'h1) rx_state_reg <= parity_en_i ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: begin
                    if (rx_centre) begin
                        rx_par_reg <= rx_par_reg ^ rxd_reg;
                        rx_state_reg <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (parity_en_i == 1'b0) rx_par_reg <= 1'b0;
                    if (rx_centre) begin
                        held_reg <= 1'b1;
                        held_word_reg <= push_word;
                        if (push_word[10]) rx_state_reg <= RX_BRK;
                        else if (fe_restart) rx_state_reg <= RX_START;
                        else rx_state_reg <= RX_HUNT;
                        rx_cnt_reg <= 4'h0;
                    end
                end
                default: begin
                    if (xtal_sync_reg[2] != xtal_sync_reg[1] && rxd_reg) brk_hi_reg <= brk_hi_reg + 2'h1;
                    if (!rxd_reg) brk_hi_reg <= 2'h0;
                    if (brk_hi_reg == 2'(asc_pkg::BREAK_HIGH_EDGES)) begin
                        rx_state_reg <= RX_HUNT;
                        brk_hi_reg <= 2'h0;
                    end
                end
            endcase
        end
    end

    asc_rx_queue u_queue (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .realign_i(rx_reset_i),
        .push_i(push),
        .push_data_i(held_word_reg),
        .pop_i(rx_read_i),
        .head_o(head),
        .count_o(count)
    );

    // ==========================================
    // Status and error accumulation
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || err_reset_i || rx_reset_i) err_acc_reg <= 3'h0;
        else if (rx_read_i && count != 2'h0) err_acc_reg <= err_acc_reg | head[10:8];
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i || rx_reset_i) begin
            rx_holding_reg_o <= asc_pkg::DATA_RESET;
            rx_char_available_o <= 1'b0;
            rx_queue_full_o <= 1'b0;
            parity_err_o <= 1'b0;
            framing_err_o <= 1'b0;
            break_flag_o <= 1'b0;
        end else begin
            rx_holding_reg_o <= head[7:0];
            rx_char_available_o <= count != 2'h0;
            rx_queue_full_o <= count == 2'(asc_pkg::QUEUE_DEPTH);
            parity_err_o <= (count != 2'h0 && head[8 + asc_pkg::ERR_PAR]) | (block_err_i & err_acc_reg[0]);
            framing_err_o <= (count != 2'h0 && head[8 + asc_pkg::ERR_FRM]) | (block_err_i & err_acc_reg[1]);
            break_flag_o <= (count != 2'h0 && head[8 + asc_pkg::ERR_BRK]) | (block_err_i & err_acc_reg[2]);
        end
    end

    // ==========================================
    // Request-to-send and interrupt routing
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rts_n_reg <= 1'b1;
            rx_rts_hold_reg <= 1'b0;
        end else begin
            if (rts_set_i) rts_n_reg <= 1'b0;
            if (tx_rts_ctrl_i && !tx_en_reg && !thr_full_reg && tx_state_reg == TX_RTS && tx_bit_end)
                rts_n_reg <= 1'b1;
            if (rx_rts_ctrl_i && rx_state_reg == RX_START && !rxd_reg && count == 2'(asc_pkg::QUEUE_DEPTH))
                rx_rts_hold_reg <= 1'b1;
            else if (count != 2'(asc_pkg::QUEUE_DEPTH)) rx_rts_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            request_to_send_out_n_o <= 1'b1;
            irq_tx_o <= 1'b0;
            irq_rx_o <= 1'b0;
            aux_out_tx_n_o <= 1'b1;
            aux_out_rx_n_o <= 1'b1;
        end else begin
            request_to_send_out_n_o <= rts_n_reg | rx_rts_hold_reg;
            irq_tx_o <= tx_holding_free_o;
            aux_out_tx_n_o <= ~(tx_irq_aux_i & tx_holding_free_o);
            irq_rx_o <= rx_int_full_i ? rx_queue_full_o : rx_char_available_o;
            aux_out_rx_n_o <= ~(rx_irq_aux_i & (rx_int_full_i ? rx_queue_full_o : rx_char_available_o));
        end
    end
endmodule : asc_channel

/* File: asc_asserts.sv */
// ==========
// Port checks
module asc_asserts (
    input wire logic clk_i, sys_rst_i, tx_write_i, tx_enable_i, tx_reset_i, break_start_i, break_stop_i,
    input wire logic rx_reset_i, err_reset_i, serial_out_chan_a_o, tx_holding_free_o, tx_all_sent_o,
    input wire logic rx_char_available_o, rx_queue_full_o, overrun_flag_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic brk_reg;
    always_ff @(posedge clk_i) begin
        brk_reg <= !(sys_rst_i || tx_reset_i || break_stop_i) && (break_start_i || brk_reg);
    end
    sequence s_brk_held;
        break_start_i && tx_all_sent_o ##1 (!break_stop_i && !tx_reset_i)[*3];
    endsequence
    a_free_clear: assert property (tx_write_i && tx_holding_free_o |=> ##1 !tx_holding_free_o)
        else $error("holding free not cleared");
    a_enable_free: assert property (tx_enable_i ##1 (!tx_write_i && !tx_reset_i)[*3] |-> tx_holding_free_o)
        else $error("holding free not set");
    a_idle_mark: assert property ((tx_all_sent_o && !brk_reg)[*3] |-> serial_out_chan_a_o)
        else $error("idle line not high");
    a_break_low: assert property (s_brk_held |-> !serial_out_chan_a_o)
        else $error("break not low");
    a_reset_idle: assert property (tx_reset_i ##1 !tx_enable_i[*3] |-> !tx_holding_free_o)
        else $error("free after reset");
    a_full_avail: assert property (rx_queue_full_o |-> rx_char_available_o)
        else $error("full without available");
    a_rx_flush: assert property (rx_reset_i |-> ##3 !rx_char_available_o && !rx_queue_full_o)
        else $error("queue not flushed");
    a_ovr_clear: assert property (err_reset_i |-> ##3 !overrun_flag_o)
        else $error("overrun not cleared");
endmodule : asc_asserts
bind asc_channel asc_asserts u_chk (.*);

/* File: asc_remote.sv */
// ==========
// Far end
module asc_remote #(parameter int BIT = 64) (
    input wire logic clk_i,
    input wire logic line_i,
    output logic line_o,
    output logic cts_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got_q[$];
    logic [7:0] d;
    logic stall = 1'h0;
    initial line_o = 1'h1;
    assign cts_n_o = stall;
    task automatic hold(input logic v, input int n);
        line_o = v;
        repeat (n * BIT) @(posedge clk_i);
        #5;
    endtask : hold
    task automatic send(input logic [7:0] v, input int n);
        hold(1'h0, 1);
        for (int i = 0; i < n; i++) hold(v[i], 1);
        hold(1'h1, 1);
    endtask : send
    initial forever begin
        @(negedge line_i);
        repeat (BIT + BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            d[i] = line_i;
            repeat (BIT) @(posedge clk_i);
        end
        got_q.push_back(d);
    end
endmodule : asc_remote

/* File: testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'h0, sys_rst_i = 1'h1, brg_clk_i = 1'h0, ct_clk_i = 1'h0, ext_rx_clk_i = 1'h0;
    logic ext_tx_clk_i = 1'h0, rx_16x_i = 1'h1, tx_16x_i = 1'h1, parity_en_i = 1'h0, parity_odd_i = 1'h0;
    logic [1:0] rx_clk_sel_i = 2'h0, tx_clk_sel_i = 2'h0, char_len_i = 2'h3, stop_bits_i = 2'h0;
    logic block_err_i = 1'h0, cts_gate_en_i = 1'h0, tx_rts_ctrl_i = 1'h1, rx_rts_ctrl_i = 1'h0, rts_set_i = 1'h0;
    logic tx_enable_i = 1'h0, tx_disable_i = 1'h0, tx_reset_i = 1'h0, rx_enable_i = 1'h0, rx_disable_i = 1'h0;
    logic rx_reset_i = 1'h0, err_reset_i = 1'h0, break_start_i = 1'h0, break_stop_i = 1'h0, tx_write_i = 1'h0;
    logic rx_read_i = 1'h0, rx_int_full_i = 1'h1, tx_irq_aux_i = 1'h1, rx_irq_aux_i = 1'h1, crystal_ref_clock_i = 1'h0;
    logic [7:0] tx_data_i = 8'h00, rx_holding_reg_o, d, q[$];
    logic serial_in_i, clear_to_send_in_n_i, serial_out_chan_a_o, request_to_send_out_n_o, tx_holding_free_o;
    logic tx_all_sent_o, rx_char_available_o, rx_queue_full_o, overrun_flag_o, parity_err_o, framing_err_o;
    logic break_flag_o, irq_tx_o, irq_rx_o, aux_out_tx_n_o, aux_out_rx_n_o;
    int fail_count = 0;
    int checks_done = 0;
    asc_channel dut (.*);
    asc_remote rem (.clk_i(clk_i), .line_i(serial_out_chan_a_o), .line_o(serial_in_i), .cts_n_o(clear_to_send_in_n_i));
    initial forever #25 clk_i = ~clk_i;
    always #100 brg_clk_i = ~brg_clk_i;
    always #35 crystal_ref_clock_i = ~crystal_ref_clock_i;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'h1;
        cyc(1);
        s = 1'h0;
        cyc(2);
    endtask : pulse
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic await(ref logic s);
        for (int k = 0; k < 2000 && s !== 1'h1; k++) cyc(1);
        chk({7'h00, s}, 8'h01);
    endtask : await
    task automatic test_done;
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    function automatic logic [7:0] trim(input logic [7:0] v, input logic [1:0] len);
        return v & (8'hFF >> (2'h3 - len));
    endfunction : trim
    initial begin
        repeat (30000) @(posedge clk_i);
        fail_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'h60CB8385));
        cyc(5);
        sys_rst_i = 1'h0;
        pulse(tx_enable_i);
        pulse(rx_enable_i);
        pulse(rts_set_i);
        for (int i = 0; i < 3; i++) begin
            q.push_back(i == 0 ? 8'h00 : 8'($urandom));
            tx_data_i = q[i];
            await(tx_holding_free_o);
            pulse(tx_write_i);
        end
        await(tx_all_sent_o);
        chk({5'h00, request_to_send_out_n_o, irq_tx_o, aux_out_tx_n_o}, 8'h02);
        foreach (q[i]) chk(rem.got_q.pop_front(), q[i]);
        pulse(tx_disable_i);
        pulse(tx_write_i);
        cyc(900);
        chk(8'(rem.got_q.size()), 8'h00);
        chk({7'h00, request_to_send_out_n_o}, 8'h01);
        pulse(tx_enable_i);
        cts_gate_en_i = 1'h1;
        rem.stall = 1'h1;
        tx_data_i = 8'hA5;
        pulse(tx_write_i);
        cyc(900);
        chk(8'(rem.got_q.size()), 8'h00);
        rem.stall = 1'h0;
        await(tx_all_sent_o);
        chk(rem.got_q.pop_front(), 8'hA5);
        pulse(break_start_i);
        cyc(100);
        chk({7'h00, serial_out_chan_a_o}, 8'h00);
        pulse(break_stop_i);
        pulse(tx_write_i);
        cyc(100);
        pulse(tx_reset_i);
        chk({6'h00, serial_out_chan_a_o, tx_holding_free_o}, 8'h02);
        cyc(900);
        for (int l = 0; l < 4; l++) begin
            char_len_i = 2'(l);
            d = 8'($urandom);
            rem.send(d, l + 5);
            await(rx_char_available_o);
            chk(rx_holding_reg_o, trim(d, 2'(l)));
            pulse(rx_read_i);
        end
        parity_en_i = 1'h1;
        char_len_i = 2'h2;
        for (int p = 0; p < 2; p++) begin
            d = 8'($urandom) & 8'h7F;
            rem.send({^d[6:0] ^ p[0], d[6:0]}, 8);
            await(rx_char_available_o);
            chk({parity_err_o, rx_holding_reg_o[6:0]}, {p[0], d[6:0]});
            pulse(rx_read_i);
        end
        parity_en_i = 1'h0;
        char_len_i = 2'h3;
        q.delete();
        for (int i = 0; i < 5; i++) begin
            q.push_back(8'($urandom));
            rem.send(q[i], 8);
        end
        cyc(3);
        chk({5'h00, overrun_flag_o, rx_queue_full_o, rx_char_available_o}, 8'h07);
        chk({4'h0, irq_rx_o, aux_out_rx_n_o, irq_tx_o, aux_out_tx_n_o}, 8'h09);
        for (int i = 0; i < 3; i++) begin
            chk(rx_holding_reg_o, q[i]);
            pulse(rx_read_i);
        end
        pulse(rx_reset_i);
        pulse(err_reset_i);
        chk({6'h00, overrun_flag_o, rx_char_available_o}, 8'h00);
        pulse(rx_enable_i);
        rem.hold(1'h0, 12);
        rem.hold(1'h1, 2);
        await(rx_char_available_o);
        chk({break_flag_o, framing_err_o, rx_holding_reg_o[5:0]}, 8'hC0);
        test_done();
    end
endmodule : testbench
